// file: arlm_pkg.sv
// Package for the long/multiple sector read command block.
// Assumes one 125 MHz core clock and a synchronous active-low reset.
package arlm_pkg;

  // ----------------------------------------------------------------
  // Task-file register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] TF_DATA = 4'h0;
  localparam logic [3:0] TF_ERR = 4'h1;
  localparam logic [3:0] TF_CNT = 4'h2;
  localparam logic [3:0] TF_LOW = 4'h3;
  localparam logic [3:0] TF_MID = 4'h4;
  localparam logic [3:0] TF_HIGH = 4'h5;
  localparam logic [3:0] TF_DEV = 4'h6;
  localparam logic [3:0] TF_CMD = 4'h7;
  localparam logic [3:0] TF_CTL = 4'h8;
  localparam logic [3:0] TF_CFG = 4'h9;

  // ----------------------------------------------------------------
  // Opcodes and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_LONG = 8'h22;
  localparam logic [7:0] OPC_RETRY_MASK = 8'hFE;
  localparam logic [7:0] OPC_MULT = 8'hC4;
  localparam logic [7:0] OPC_MULT_EXT = 8'h29;
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_DSC = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_UNC = 6;
  localparam int ER_ABT = 2;
  localparam int DEV_L = 6;
  localparam int DEV_D = 4;
  localparam int CTL_HOB = 7;
  localparam int CFG_ECC40 = 0;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] DEV_RST = 8'hA0;
  localparam logic [15:0] CFG_RST = 16'h0100;
  localparam logic [7:0] LAST_WORD = 8'hFF;
  localparam logic [5:0] ECC_SHORT = 6'h04;
  localparam logic [5:0] ECC_LONG = 6'h28;
  localparam int ECC_MEDIA = 40;
  localparam int ECC_FOLDS = 10;
  localparam logic [16:0] CNT_ONE = 17'h00001;
  localparam logic [16:0] MULT28_ZERO = 17'h00100;
  localparam logic [16:0] MULT48_ZERO = 17'h10000;
  localparam logic [7:0] GEO_SPT = 8'h3F;
  localparam logic [3:0] GEO_HEAD_MAX = 4'hF;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_XFER,
    ST_ECCX
  } arlm_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } arlm_tf_req_t;

  typedef struct packed {
    logic word_we;
    logic [15:0] word;
    logic ecc_we;
    logic [7:0] ecc;
    logic done;
    logic unc;
  } arlm_med_in_t;

endpackage

// file: arlm_reader.sv
// Task-file command engine for long, multiple and extended multiple reads.
// Assumes the host port and media port are on core_clk; the slave strap
// comes from a pin and is synchronised here.
//
// Operation
// - Opcodes 22h and 23h start a long read; the retry bit is ignored.
// - After 512 data bytes, DRQ stays set while ECC bytes are offered.
// - Long read moves data as 16-bit words, ECC as single bytes.
// - ECC byte count is 4 or 40 from a setting, default 4.
// - Long read: one media attempt, no correction, raw data returned.
// - Address is CHS when mode bit is 0, 28-bit LBA when 1.
// - Long read completion returns the transferred sector's address.
// - Media keeps 40 ECC bytes; 4-byte form is emulated from them.
// - Opcode C4h starts a multi-sector PIO read.
// - Multi-sector read interrupts once per block, not per sector.
// - A 28-bit multi-sector count of zero means 256 sectors.
// - Multi-sector data moves as 16-bit words.
// - Afterwards sector count holds sectors not transferred.
// - Afterwards address registers hold the last transferred sector, or the failing one on error.
// - Opcode 29h starts the 48-bit extended multi-sector read.
// - Extended count is 16 bits; all zero means 65536 sectors.
// - Extended error shows failing LBA: bits 23-0, or 47-24 with HOB.
// - Mode bit selects CHS when 0, LBA when 1; opcode 29h uses LBA either way.
// - Drive-select bit picks master or slave; only that drive acts.
module arlm_reader
  import arlm_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Task-file register port
  input wire arlm_tf_req_t tf,
  output logic [15:0] rdata_q,
  output logic intrq_q,
  // Drive strap pin
  input wire logic slave_strap,
  // Media port
  input wire arlm_med_in_t med,
  output logic med_start_q,
  output logic [47:0] med_addr_q,
  output logic med_lba_q,
  output logic med_raw_q
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] arlm_push(input logic [15:0] r,
                                           input logic [7:0] b);
    return {r[7:0], b};
  endfunction

  function automatic logic [7:0] arlm_pick(input logic [15:0] r,
                                          input logic hob);
    return hob ? r[15:8] : r[7:0];
  endfunction

  // CHS walks sector, then head, then cylinder
  function automatic logic [47:0] arlm_next_addr(input logic [47:0] a,
                                                input logic lin);
    logic [47:0] n;
    n = a;
    if (lin) begin
      n = a + 48'h1;
    end else if (a[7:0] >= GEO_SPT) begin
      n[7:0] = 8'h01;
      if (a[27:24] >= GEO_HEAD_MAX) begin
        n[27:24] = 4'h0;
        n[23:8] = a[23:8] + 16'h1;
      end else begin
        n[27:24] = a[27:24] + 4'h1;
      end
    end else begin
      n[7:0] = a[7:0] + 8'h01;
    end
    return n;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  arlm_state_t st_q;
  logic [15:0] cnt_q, low_q, mid_q, high_q, cfg_q;
  logic [7:0] dev_q, err_q, rd_ptr_q, wr_ptr_q, blk_pos_q;
  logic [5:0] ecc_ptr_q, ecc_wr_q, ecc_len_q;
  logic [16:0] rem_q;
  logic hob_q, err_flag_q, long_q, ext_q, strap_m_q, strap_q;
  logic [15:0] buf_mem [256];
  logic [7:0] ecc_mem [ECC_MEDIA];

  // Strap pin crosses in through two flops
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      strap_m_q <= 1'b0;
      strap_q <= 1'b0;
    end else begin
      strap_m_q <= slave_strap;
      strap_q <= strap_m_q;
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire [7:0] opc = tf.wdata[7:0];
  wire sel = (dev_q[DEV_D] == strap_q);
  wire cmd_wr = tf.wr && (tf.addr == TF_CMD) && (st_q == ST_IDLE);
  wire is_long = ((opc & OPC_RETRY_MASK) == OPC_LONG);
  wire is_mult = (opc == OPC_MULT);
  wire is_ext = (opc == OPC_MULT_EXT);
  wire long_bad = is_long && (cnt_q[7:0] != 8'h01);
  wire cmd_ok = (is_long && !long_bad) || is_mult || is_ext;
  wire cmd_go = cmd_wr && sel && cmd_ok;
  wire cmd_abort = cmd_wr && sel && !cmd_ok;
  wire [16:0] rem28 = (cnt_q[7:0] == 8'h00) ? MULT28_ZERO :
                      {9'h000, cnt_q[7:0]};
  wire [16:0] rem48 = (cnt_q == 16'h0000) ? MULT48_ZERO :
                      {1'b0, cnt_q};
  wire [16:0] start_rem = is_long ? CNT_ONE : (is_ext ? rem48 : rem28);
  wire [47:0] addr48 = {high_q[15:8], mid_q[15:8], low_q[15:8],
                        high_q[7:0], mid_q[7:0], low_q[7:0]};
  wire [47:0] addr28 = {20'h00000, dev_q[3:0], high_q[7:0],
                        mid_q[7:0], low_q[7:0]};
  wire [7:0] blk_sz = (cfg_q[15:8] == 8'h00) ? 8'h01 : cfg_q[15:8];

  // ----------------------------------------------------------------
  // Transfer events
  // ----------------------------------------------------------------
  wire data_rd = tf.rd && (tf.addr == TF_DATA);
  wire data_pop = data_rd && (st_q == ST_XFER);
  wire ecc_pop = data_rd && (st_q == ST_ECCX);
  wire last_word = data_pop && (rd_ptr_q == LAST_WORD);
  wire last_ecc = ecc_pop && (ecc_ptr_q == ecc_len_q - 6'h01);
  wire media_end = (st_q == ST_FETCH) && med.done;
  // Raw long read never fails on media error
  wire media_fail = media_end && med.unc && !long_q;
  wire sect_end = last_word && !long_q;
  wire next_fetch = sect_end && (rem_q != CNT_ONE);
  wire wb_go = media_fail || sect_end || last_ecc;
  wire [16:0] wb_rem = media_fail ? rem_q : rem_q - CNT_ONE;
  wire stat_rd = tf.rd && (tf.addr == TF_CMD);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: if (cmd_go) st_q <= ST_FETCH;
        ST_FETCH: begin
          if (media_fail) st_q <= ST_IDLE;
          else if (media_end) st_q <= ST_XFER;
        end
        ST_XFER: begin
          if (last_word && long_q) st_q <= ST_ECCX;
          else if (next_fetch) st_q <= ST_FETCH;
          else if (last_word) st_q <= ST_IDLE;
        end
        ST_ECCX: if (last_ecc) st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      long_q <= 1'b0;
      ext_q <= 1'b0;
      ecc_len_q <= ECC_SHORT;
      med_lba_q <= 1'b0;
      med_raw_q <= 1'b0;
    end else if (cmd_go) begin
      long_q <= is_long;
      ext_q <= is_ext;
      ecc_len_q <= cfg_q[CFG_ECC40] ? ECC_LONG : ECC_SHORT;
      med_lba_q <= is_ext || dev_q[DEV_L];
      med_raw_q <= is_long;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      med_start_q <= 1'b0;
      med_addr_q <= '0;
      rem_q <= '0;
      blk_pos_q <= '0;
    end else begin
      med_start_q <= cmd_go || next_fetch;
      if (cmd_go) begin
        med_addr_q <= is_ext ? addr48 : addr28;
        rem_q <= start_rem;
        blk_pos_q <= 8'h00;
      end else if (sect_end) begin
        rem_q <= rem_q - CNT_ONE;
        blk_pos_q <= (blk_pos_q + 8'h01 == blk_sz) ? 8'h00 :
                     blk_pos_q + 8'h01;
        if (next_fetch) begin
          med_addr_q <= arlm_next_addr(med_addr_q, ext_q || med_lba_q);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Sector and ECC buffer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n || med_start_q) begin
      wr_ptr_q <= '0;
      ecc_wr_q <= '0;
    end else begin
      if (med.word_we) wr_ptr_q <= wr_ptr_q + 8'h01;
      if (med.ecc_we) ecc_wr_q <= ecc_wr_q + 6'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (med.word_we) buf_mem[wr_ptr_q] <= med.word;
    if (med.ecc_we) ecc_mem[ecc_wr_q] <= med.ecc;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || media_end) begin
      rd_ptr_q <= '0;
      ecc_ptr_q <= '0;
    end else begin
      if (data_pop) rd_ptr_q <= rd_ptr_q + 8'h01;
      if (ecc_pop) ecc_ptr_q <= ecc_ptr_q + 6'h01;
    end
  end

  // Short form folds the stored 40 bytes into 4
  logic [7:0] ecc_out;
  always_comb begin
    ecc_out = 8'h00;
    if (ecc_len_q == ECC_LONG) begin
      ecc_out = ecc_mem[ecc_ptr_q];
    end else begin
      for (int k = 0; k < ECC_FOLDS; k++) begin
        ecc_out = ecc_out ^ ecc_mem[int'(ecc_ptr_q[1:0]) + 4 * k];
      end
    end
  end

  // ----------------------------------------------------------------
  // Task-file registers
  // ----------------------------------------------------------------
  wire host_wr = tf.wr && (st_q == ST_IDLE);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      low_q <= '0;
      mid_q <= '0;
      high_q <= '0;
      dev_q <= DEV_RST;
      hob_q <= 1'b0;
      cfg_q <= CFG_RST;
    end else if (wb_go) begin
      cnt_q <= wb_rem[15:0];
      low_q <= {med_addr_q[31:24], med_addr_q[7:0]};
      mid_q <= {med_addr_q[39:32], med_addr_q[15:8]};
      high_q <= {med_addr_q[47:40], med_addr_q[23:16]};
      if (!ext_q) dev_q[3:0] <= med_addr_q[27:24];
    end else if (host_wr) begin
      if (tf.addr == TF_CNT) cnt_q <= arlm_push(cnt_q, opc);
      else if (tf.addr == TF_LOW) low_q <= arlm_push(low_q, opc);
      else if (tf.addr == TF_MID) mid_q <= arlm_push(mid_q, opc);
      else if (tf.addr == TF_HIGH) high_q <= arlm_push(high_q, opc);
      else if (tf.addr == TF_DEV) dev_q <= opc;
      else if (tf.addr == TF_CTL) hob_q <= opc[CTL_HOB];
      else if (tf.addr == TF_CFG) cfg_q <= tf.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      err_q <= '0;
      err_flag_q <= 1'b0;
    end else if (cmd_go) begin
      err_q <= '0;
      err_flag_q <= 1'b0;
    end else if (cmd_abort) begin
      err_q <= 8'h01 << ER_ABT;
      err_flag_q <= 1'b1;
    end else if (media_fail) begin
      err_q <= 8'h01 << ER_UNC;
      err_flag_q <= 1'b1;
    end
  end

  // Set beats a same-cycle status read
  wire intr_set = cmd_abort || media_fail ||
                  (media_end && !media_fail && blk_pos_q == 8'h00);
  always_ff @(posedge core_clk) begin
    if (!rst_n) intrq_q <= 1'b0;
    else if (intr_set) intrq_q <= 1'b1;
    else if (stat_rd || cmd_wr) intrq_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------
  logic [7:0] stat_v;
  always_comb begin
    stat_v = 8'h00;
    stat_v[ST_BSY] = (st_q == ST_FETCH);
    stat_v[ST_RDY] = 1'b1;
    stat_v[ST_DSC] = 1'b1;
    stat_v[ST_DRQ] = (st_q == ST_XFER) || (st_q == ST_ECCX);
    stat_v[ST_ERR] = err_flag_q;
  end

  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (tf.addr == TF_DATA) begin
      if (st_q == ST_XFER) rd_mux = buf_mem[rd_ptr_q];
      else if (st_q == ST_ECCX) rd_mux = {8'h00, ecc_out};
    end else if (tf.addr == TF_ERR) rd_mux = {8'h00, err_q};
    else if (tf.addr == TF_CNT) rd_mux = {8'h00, arlm_pick(cnt_q, hob_q)};
    else if (tf.addr == TF_LOW) rd_mux = {8'h00, arlm_pick(low_q, hob_q)};
    else if (tf.addr == TF_MID) rd_mux = {8'h00, arlm_pick(mid_q, hob_q)};
    else if (tf.addr == TF_HIGH) rd_mux = {8'h00, arlm_pick(high_q, hob_q)};
    else if (tf.addr == TF_DEV) rd_mux = {8'h00, dev_q};
    else if (tf.addr == TF_CMD || tf.addr == TF_CTL) begin
      rd_mux = sel ? {8'h00, stat_v} : 16'h0000;
    end else if (tf.addr == TF_CFG) rd_mux = cfg_q;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) rdata_q <= '0;
    else if (tf.rd) rdata_q <= rd_mux;
    else rdata_q <= '0;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_fin_req;
    (last_word && !long_q && rem_q == CNT_ONE) || last_ecc;
  endsequence
  sequence s_quiet;
    (st_q == ST_IDLE) && !stat_v[ST_DRQ] && !stat_v[ST_BSY];
  endsequence

  AST_LONG_RETRY_IGN: assert property (
    cmd_go && is_long |=> st_q == ST_FETCH && long_q && rem_q == CNT_ONE
  ) else $error("long read not started alike for both opcodes");
  AST_LONG_ABORT: assert property (
    cmd_wr && sel && long_bad |=> st_q == ST_IDLE && err_q[ER_ABT] &&
    err_flag_q && !med_start_q
  ) else $error("bad long read count not aborted");
  AST_ECC_DRQ: assert property (
    last_word && long_q |=> st_q == ST_ECCX && stat_v[ST_DRQ]
  ) else $error("DRQ dropped before ECC bytes");
  AST_ECC_BYTE: assert property (
    ecc_pop |=> rdata_q[15:8] == 8'h00
  ) else $error("ECC access wider than a byte");
  AST_ECC_LEN: assert property (
    cmd_go && is_long |=> ecc_len_q ==
    ($past(cfg_q[CFG_ECC40]) ? ECC_LONG : ECC_SHORT)
  ) else $error("ECC byte count wrong");
  AST_RAW: assert property (
    long_q && med.done && med.unc && st_q == ST_FETCH |=> st_q == ST_XFER
  ) else $error("long read stopped on media error");
  AST_BLOCK_INTR: assert property (
    media_end && !media_fail && blk_pos_q == 8'h00 |=> intrq_q
  ) else $error("no interrupt at block start");
  AST_MULT_ZERO: assert property (
    cmd_go && is_mult && cnt_q[7:0] == 8'h00 |=> rem_q == MULT28_ZERO
  ) else $error("zero count not 256 sectors");
  AST_CNT_LEFT: assert property (
    sect_end && rem_q == CNT_ONE |=> cnt_q == 16'h0000
  ) else $error("count not zero after full read");
  AST_EXT_ZERO: assert property (
    cmd_go && is_ext && cnt_q == 16'h0000 |=> rem_q == MULT48_ZERO
  ) else $error("zero extended count not 65536");
  AST_EXT_ERR: assert property (
    media_fail && ext_q |=> low_q == {$past(med_addr_q[31:24]),
    $past(med_addr_q[7:0])}
  ) else $error("failing LBA not reported");
  AST_UNSEL: assert property (
    cmd_wr && !sel |=> st_q == ST_IDLE && !med_start_q
  ) else $error("unselected drive acted");
  AST_FINISH: assert property (
    s_fin_req |=> s_quiet
  ) else $error("BSY or DRQ left set at end");

endmodule

// file: arlm_media_model.sv
// Media model for the read engine: sector words, ECC bytes, then done.
// Assumes med_start_q pulses once per sector and done is awaited.
module arlm_media_model
  import arlm_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Requests from the engine
  input wire logic med_start_q,
  input wire logic [47:0] med_addr_q,
  // Scenario controls
  input wire logic [3:0] gap,
  input wire logic unc_en,
  input wire logic [47:0] unc_addr,
  // Answers to the engine
  output arlm_med_in_t med
);
  logic busy_q;
  logic [8:0] idx_q;
  logic [3:0] wait_q;
  logic [47:0] a_q;

  // Idle lines show the inverse of the last value, never a held copy
  always_ff @(posedge core_clk) begin
    med.word_we <= 1'b0;
    med.ecc_we <= 1'b0;
    med.done <= 1'b0;
    med.unc <= 1'b0;
    med.word <= ~med.word;
    med.ecc <= ~med.ecc;
    if (!rst_n) begin
      busy_q <= 1'b0;
      med.word <= 16'h0000;
      med.ecc <= 8'h00;
    end else if (med_start_q) begin
      busy_q <= 1'b1;
      idx_q <= 9'h000;
      wait_q <= gap;
      a_q <= med_addr_q;
    end else if (busy_q && wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end else if (busy_q) begin
      wait_q <= gap;
      idx_q <= idx_q + 9'h001;
      if (idx_q < 9'h100) begin
        med.word_we <= 1'b1;
        med.word <= {a_q[7:0], idx_q[7:0]};
      end else if (idx_q < 9'h128) begin
        med.ecc_we <= 1'b1;
        med.ecc <= idx_q[7:0] + a_q[7:0];
      end else begin
        med.done <= 1'b1;
        med.unc <= unc_en && a_q == unc_addr;
        busy_q <= 1'b0;
      end
    end
  end
endmodule

// file: arlm_reader_tb.sv
// Self-checking bench for the long, multiple and extended read engine.
// Assumes the media model answers every sector start in full.
module arlm_reader_tb
  import arlm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_n, slave_strap, intrq_q, med_start_q;
  logic med_lba_q, med_raw_q, unc_en;
  arlm_tf_req_t tf;
  arlm_med_in_t med;
  logic [15:0] rdata_q;
  logic [47:0] med_addr_q, unc_addr;
  logic [3:0] gap;
  int err_count = 0;
  int n_compared = 0;
  int n_starts = 0;

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  arlm_reader i_dut (.core_clk(core_clk), .rst_n(rst_n), .tf(tf),
    .rdata_q(rdata_q), .intrq_q(intrq_q), .slave_strap(slave_strap),
    .med(med), .med_start_q(med_start_q), .med_addr_q(med_addr_q),
    .med_lba_q(med_lba_q), .med_raw_q(med_raw_q));
  arlm_media_model i_media (.core_clk(core_clk), .rst_n(rst_n),
    .med_start_q(med_start_q), .med_addr_q(med_addr_q), .gap(gap),
    .unc_en(unc_en), .unc_addr(unc_addr), .med(med));

  always @(posedge core_clk) begin
    if (med_start_q === 1'b1) n_starts <= n_starts + 1;
  end

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    tf <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    tf.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    tf <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge core_clk);
    tf.rd <= 1'b0;
    #1 d = rdata_q;
  endtask

  task automatic wait_st(input logic [7:0] mask, output logic [15:0] s);
    int n;
    n = 0;
    do begin
      rd(TF_CTL, s);
      n++;
    end while ((s[7] !== 1'b0 || (s[7:0] & mask) == 8'h00) && n < 4000);
    if (n >= 4000) begin
      err_count++;
      $display("FAIL t=%0t status wait ran out", $time);
    end
  endtask

  task automatic setup(input logic [15:0] c, input logic [47:0] l,
      input logic [7:0] dv);
    wr(TF_CNT, {8'h00, c[15:8]});
    wr(TF_CNT, {8'h00, c[7:0]});
    wr(TF_LOW, {8'h00, l[31:24]});
    wr(TF_LOW, {8'h00, l[7:0]});
    wr(TF_MID, {8'h00, l[39:32]});
    wr(TF_MID, {8'h00, l[15:8]});
    wr(TF_HIGH, {8'h00, l[47:40]});
    wr(TF_HIGH, {8'h00, l[23:16]});
    wr(TF_DEV, {8'h00, dv});
  endtask

  task automatic rd_sec(input logic [7:0] b);
    logic [15:0] d;
    for (int i = 0; i < 256; i++) begin
      rd(TF_DATA, d);
      chk(d, {b, i[7:0]});
    end
  endtask

  // Current bytes with readback clear, previous bytes with it set
  task automatic chk_addr(input logic [15:0] c, input logic [47:0] l);
    logic [15:0] s;
    rd(TF_CNT, s);
    chk(s, {8'h00, c[7:0]});
    rd(TF_LOW, s);
    chk(s, {8'h00, l[7:0]});
    rd(TF_MID, s);
    chk(s, {8'h00, l[15:8]});
    rd(TF_HIGH, s);
    chk(s, {8'h00, l[23:16]});
    wr(TF_CTL, 16'h0080);
    rd(TF_CNT, s);
    chk(s, {8'h00, c[15:8]});
    rd(TF_LOW, s);
    chk(s, {8'h00, l[31:24]});
    rd(TF_MID, s);
    chk(s, {8'h00, l[39:32]});
    rd(TF_HIGH, s);
    chk(s, {8'h00, l[47:40]});
    wr(TF_CTL, 16'h0000);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_long(input logic [7:0] op, input logic e40,
      input logic [7:0] dv, input logic [23:0] l);
    logic [15:0] s;
    logic [7:0] x;
    int st;
    if (e40) wr(TF_CFG, 16'h0101);
    // Media flags this sector bad; a raw read must still hand it over
    unc_addr <= {20'h0, dv[3:0], l};
    unc_en <= 1'b1;
    setup(16'h0001, {24'h0, l}, dv);
    st = n_starts;
    wr(TF_CMD, {8'h00, op});
    wait_st(8'h08, s);
    chk({15'h0, med_addr_q === {20'h0, dv[3:0], l}}, 16'h0001);
    chk({14'h0, med_raw_q, med_lba_q}, {14'h0, 1'b1, dv[6]});
    rd_sec(l[7:0]);
    rd(TF_CTL, s);
    chk(s & 16'h0088, 16'h0008);
    for (int i = 0; i < (e40 ? 40 : 4); i++) begin
      x = 8'h00;
      if (e40) x = 8'(i) + l[7:0];
      else for (int k = 0; k < 10; k++) x ^= 8'(i + 4 * k) + l[7:0];
      rd(TF_DATA, s);
      chk(s, {8'h00, x});
    end
    rd(TF_CTL, s);
    chk(s & 16'h0089, 16'h0000);
    chk_addr(16'h0000, {20'h0, dv[3:0], l});
    rd(TF_DEV, s);
    chk({12'h0, s[3:0]}, {12'h0, dv[3:0]});
    chk(16'(n_starts - st), 16'h0001);
    unc_en <= 1'b0;
  endtask

  task automatic t_abort;
    logic [15:0] s;
    int st;
    setup(16'h0002, 48'h10, 8'hE0);
    st = n_starts;
    wr(TF_CMD, {8'h00, OPC_LONG});
    wait_st(8'h01, s);
    chk(s & 16'h0089, 16'h0001);
    rd(TF_ERR, s);
    chk(s, 16'h0004);
    chk({15'h0, intrq_q}, 16'h0001);
    chk(16'(n_starts - st), 16'h0000);
  endtask

  task automatic t_unsel;
    logic [15:0] s;
    int st;
    setup(16'h0001, 48'h10, 8'hF0);
    st = n_starts;
    wr(TF_CMD, {8'h00, OPC_MULT});
    repeat (20) @(posedge core_clk);
    chk(16'(n_starts - st), 16'h0000);
    rd(TF_CTL, s);
    chk(s, 16'h0000);
  endtask

  task automatic t_mult;
    logic [15:0] s;
    wr(TF_CFG, 16'h0200);
    // CHS start at the second-last sector so the walk wraps to head 1
    setup(16'h0003, 48'h3E, 8'hA0);
    wr(TF_CMD, {8'h00, OPC_MULT});
    for (int n = 0; n < 3; n++) begin
      wait_st(8'h08, s);
      chk({15'h0, intrq_q}, {15'h0, n[0] == 1'b0});
      if (n[0] == 1'b0) rd(TF_CMD, s);
      rd_sec(n == 2 ? 8'h01 : 8'h3E + n[7:0]);
    end
    rd(TF_CTL, s);
    chk(s & 16'h0089, 16'h0000);
    chk_addr(16'h0000, 48'h01000001);
  endtask

  task automatic t_unc(input logic [7:0] op, input logic [47:0] l,
      input logic [15:0] rem);
    logic [15:0] s;
    wr(TF_CFG, 16'h0100);
    unc_addr <= l + 48'h1;
    unc_en <= 1'b1;
    setup(16'h0000, l, 8'hE0);
    wr(TF_CMD, {8'h00, op});
    wait_st(8'h08, s);
    chk({15'h0, med_addr_q === l}, 16'h0001);
    chk({14'h0, med_raw_q, med_lba_q}, 16'h0001);
    rd_sec(l[7:0]);
    wait_st(8'h01, s);
    rd(TF_ERR, s);
    chk(s, 16'h0040);
    chk_addr(rem, l + 48'h1);
    unc_en <= 1'b0;
  endtask

  initial begin
    logic [15:0] s;
    rst_n = 1'b0;
    slave_strap = 1'b0;
    tf = '0;
    gap = 4'h0;
    unc_en = 1'b0;
    unc_addr = 48'h0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(TF_DEV, s);
    chk(s, {8'h00, DEV_RST});
    t_long(8'h23, 1'b0, 8'hE5, 24'h123456);
    t_long(OPC_LONG, 1'b1, 8'hA3, 24'h020705);
    t_abort;
    t_unsel;
    gap <= 4'h3;
    t_mult;
    gap <= 4'h0;
    t_unc(OPC_MULT, 48'h20, 16'h00FF);
    t_unc(OPC_MULT_EXT, 48'hA1B2C3D4E5F0, 16'hFFFF);
    report_and_stop;
  end

  // Whole run needs about a sixth of this
  initial begin
    repeat (60000) @(posedge core_clk);
    err_count++;
    $display("FAIL t=%0t run did not finish", $time);
    report_and_stop;
  end
endmodule
